// *** hdl/lfp_defines.svh ***
`ifndef LFP_DEFINES_SVH
`define LFP_DEFINES_SVH

// ==================================================
// bus and register map
`define LFP_ADDR_W 4
`define LFP_REG_STATUS 4'h0
`define LFP_REG_CMD 4'h4
`define LFP_REG_RESULT 4'h8
`define LFP_RESP_OKAY 2'h0
`define LFP_RESP_SLVERR 2'h2

// ==================================================
// nonvolatile bit layout, blank state is all ones
`define LFP_NV_W 6
`define LFP_NV_LOCK_FIRST 0
`define LFP_NV_LOCK_SECOND 1
`define LFP_NV_SERIAL_EN 2
`define LFP_NV_STARTUP_LO 3
`define LFP_NV_STARTUP_HI 4
`define LFP_NV_PRESERVE 5
`define LFP_NV_BLANK 6'h3F

// ==================================================
// command word fields
`define LFP_CMD_OP_LO 0
`define LFP_CMD_OP_HI 2
`define LFP_CMD_SERIAL 3
`define LFP_CMD_LOCK_LO 4
`define LFP_CMD_LOCK_HI 5
`define LFP_CMD_FUSE_LO 8
`define LFP_CMD_FUSE_HI 11

// ==================================================
// status and result fields
`define LFP_STAT_LOCKED 8
`define LFP_STAT_READY 9
`define LFP_RES_ACCEPT 0
`define LFP_RES_REFUSE 1
`define LFP_RES_OP_LO 4
`define LFP_RES_OP_HI 6

// ==================================================
// start-up timing
`define LFP_CLK_HZ 40000000
`define LFP_STARTUP_MS_DEFAULT 16
`define LFP_STARTUP_CNT_W 20

`endif

// *** hdl/lfp_pkg.sv ***
package lfp_pkg;

  typedef enum logic [2:0] {
    LFP_OP_NONE = 3'b000,
    LFP_OP_LOCK = 3'b001,
    LFP_OP_FUSE = 3'b010,
    LFP_OP_ERASE = 3'b011,
    LFP_OP_FLASH = 3'b100,
    LFP_OP_EEPROM = 3'b101
  } lfp_op_e;

  typedef enum logic [0:0] {
    LFP_ST_DELAY = 1'b0,
    LFP_ST_READY = 1'b1
  } lfp_st_e;

endpackage : lfp_pkg

// *** hdl/lfp_nv_store.sv ***
`timescale 1ns/10ps
`include "lfp_defines.svh"

module lfp_nv_store
  import lfp_pkg::*;
#(
  parameter int unsigned WIDTH = `LFP_NV_W
) (
  // clock and control
  input wire logic mclk_i,
  input wire logic ce_i,
  input wire logic blank_i,
  // write side
  input wire logic we_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read side
  output logic [WIDTH-1:0] rdata_o
);

  // ==================================================
  // storage
  // not touched by the system reset: these bits outlive it
  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (blank_i) begin
        rdata_o <= WIDTH'(`LFP_NV_BLANK);
      end else if (we_i) begin
        rdata_o <= wdata_i;
      end
    end
  end

endmodule : lfp_nv_store

// *** hdl/lfp_top.sv ***
`timescale 1ns/10ps
`include "lfp_defines.svh"

module lfp_top
  import lfp_pkg::*;
#(
  parameter int unsigned CNT_W = `LFP_STARTUP_CNT_W,
  parameter int unsigned STARTUP_CYC_11 = (`LFP_STARTUP_MS_DEFAULT * (`LFP_CLK_HZ / 1000)),
  parameter int unsigned STARTUP_CYC_10 = 160000,
  parameter int unsigned STARTUP_CYC_01 = 40000,
  parameter int unsigned STARTUP_CYC_00 = 4
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic nv_blank_i,
  // axi4-lite write
  input wire logic [`LFP_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [`LFP_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // memory control
  output logic flash_write_allow_o,
  output logic flash_prog_o,
  output logic eeprom_prog_o,
  output logic erase_flash_o,
  output logic erase_eeprom_o,
  output logic serial_download_en_o,
  output logic startup_done_o
);

  // ==================================================
  // functions
  function automatic logic [CNT_W-1:0] startup_cycles(input logic [1:0] sel);
    case (sel)
      2'b11: startup_cycles = CNT_W'(STARTUP_CYC_11);
      2'b10: startup_cycles = CNT_W'(STARTUP_CYC_10);
      2'b01: startup_cycles = CNT_W'(STARTUP_CYC_01);
      default: startup_cycles = CNT_W'(STARTUP_CYC_00);
    endcase
  endfunction : startup_cycles

  // ==================================================
  // write channel capture
  logic [`LFP_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic aw_have_q;
  logic w_have_q;
  logic [`LFP_NV_W-1:0] nv;
  logic [2:0] res_op_q;
  logic res_ok_q;
  logic res_ref_q;
  lfp_st_e st_q;
  logic [CNT_W-1:0] cnt_q;

  wire aw_take = ce_i && s_axi_awvalid_i && s_axi_awready_o;
  wire w_take = ce_i && s_axi_wvalid_i && s_axi_wready_o;
  wire wr_fire = ce_i && aw_have_q && w_have_q && !s_axi_bvalid_o;
  wire wr_is_cmd = (awaddr_q == `LFP_REG_CMD);
  wire cmd_fire = wr_fire && wr_is_cmd;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `LFP_RESP_OKAY;
    end else if (ce_i) begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr_i;
        aw_have_q <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata_i;
        w_have_q <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_is_cmd ? `LFP_RESP_OKAY : `LFP_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ==================================================
  // command decode
  // strobes are ignored: a command word only makes sense whole
  lfp_op_e op;
  assign op = lfp_op_e'(wdata_q[`LFP_CMD_OP_HI:`LFP_CMD_OP_LO]);
  wire ser = wdata_q[`LFP_CMD_SERIAL];
  wire [1:0] lock_new = wdata_q[`LFP_CMD_LOCK_HI:`LFP_CMD_LOCK_LO];
  wire [3:0] fuse_new = wdata_q[`LFP_CMD_FUSE_HI:`LFP_CMD_FUSE_LO];
  wire [1:0] lock_cur = nv[`LFP_NV_LOCK_SECOND:`LFP_NV_LOCK_FIRST];
  wire [3:0] fuse_cur = nv[`LFP_NV_PRESERVE:`LFP_NV_SERIAL_EN];
  // only the first lock bit decides locked: the second lock bit programmed alone leaves the part unlocked
  wire locked = !lock_cur[0];
  wire any_lock = !(&lock_cur);
  wire ser_ok = !nv[`LFP_NV_SERIAL_EN];
  wire serial_download_enable_fuse_chg = (fuse_new[0] != fuse_cur[0]);
  wire pres_prog = fuse_cur[3] && !fuse_new[3];

  wire ref_ser = ser && !ser_ok;
  wire ref_lock = (op == LFP_OP_LOCK) && ser;
  wire ref_fuse = (op == LFP_OP_FUSE) &&
                  (locked || (ser && serial_download_enable_fuse_chg) || (pres_prog && any_lock));
  wire ref_mem = ((op == LFP_OP_FLASH) || (op == LFP_OP_EEPROM)) && locked;
  wire op_bad = (op == LFP_OP_NONE) || (op > LFP_OP_EEPROM);
  wire refuse = ref_ser || ref_lock || ref_fuse || ref_mem || op_bad;
  wire accept = cmd_fire && !refuse;

  // ==================================================
  // nonvolatile update
  logic [`LFP_NV_W-1:0] nv_d;
  always_comb begin
    nv_d = nv;
    case (op)
      LFP_OP_LOCK: nv_d[1:0] = lock_cur & lock_new;
      LFP_OP_FUSE: nv_d[5:2] = fuse_new;
      LFP_OP_ERASE: nv_d[1:0] = 2'b11;
      default: nv_d = nv;
    endcase
  end

  lfp_nv_store #(
    .WIDTH(`LFP_NV_W)
  ) u_store (
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .blank_i(nv_blank_i),
    .we_i(accept),
    .wdata_i(nv_d),
    .rdata_o(nv)
  );

  // ==================================================
  // memory strobes and result
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flash_prog_o <= 1'b0;
      eeprom_prog_o <= 1'b0;
      erase_flash_o <= 1'b0;
      erase_eeprom_o <= 1'b0;
      flash_write_allow_o <= 1'b0;
      serial_download_en_o <= 1'b0;
      res_op_q <= 3'h0;
      res_ok_q <= 1'b0;
      res_ref_q <= 1'b0;
    end else if (ce_i) begin
      flash_prog_o <= accept && (op == LFP_OP_FLASH);
      eeprom_prog_o <= accept && (op == LFP_OP_EEPROM);
      erase_flash_o <= accept && (op == LFP_OP_ERASE);
      erase_eeprom_o <= accept && (op == LFP_OP_ERASE) && nv[`LFP_NV_PRESERVE];
      flash_write_allow_o <= !locked;
      serial_download_en_o <= ser_ok;
      if (cmd_fire) begin
        res_op_q <= op;
        res_ok_q <= !refuse;
        res_ref_q <= refuse;
      end
    end
  end

  // ==================================================
  // start-up delay
  // the start-up fuses, read live throughout the delay, decide the wait
  wire [CNT_W-1:0] cnt_end = startup_cycles(nv[`LFP_NV_STARTUP_HI:`LFP_NV_STARTUP_LO]);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= LFP_ST_DELAY;
      cnt_q <= '0;
      startup_done_o <= 1'b0;
    end else if (ce_i) begin
      case (st_q)
        LFP_ST_DELAY: begin
          if (cnt_q >= cnt_end - CNT_W'(1)) begin
            st_q <= LFP_ST_READY;
            startup_done_o <= 1'b1;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        LFP_ST_READY: startup_done_o <= 1'b1;
        default: st_q <= LFP_ST_DELAY;
      endcase
    end
  end

  // ==================================================
  // read channel
  wire [31:0] stat_word = {22'h0, startup_done_o, locked, 2'h0, nv};
  wire [31:0] res_word = {25'h0, res_op_q, 2'h0, res_ref_q, res_ok_q};
  wire ar_take = ce_i && s_axi_arvalid_i && s_axi_arready_o;
  wire rd_stat = (s_axi_araddr_i == `LFP_REG_STATUS);
  wire rd_res = (s_axi_araddr_i == `LFP_REG_RESULT);
  wire [31:0] rd_word = rd_stat ? stat_word : (rd_res ? res_word : 32'h0);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= `LFP_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= (rd_stat || rd_res) ? `LFP_RESP_OKAY : `LFP_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ==================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i || nv_blank_i);

  a_locked_mem_refused: assert property (
    cmd_fire && (op == LFP_OP_FLASH) && locked |=> !flash_prog_o && res_ref_q
  ) else $error("flash programmed while locked");

  a_lock_no_serial: assert property (
    cmd_fire && (op == LFP_OP_LOCK) && ser |=> nv[1:0] == $past(nv[1:0])
  ) else $error("lock bits changed over serial path");

  a_locked_fuse_hold: assert property (
    cmd_fire && (op == LFP_OP_FUSE) && locked |=> nv[5:2] == $past(nv[5:2])
  ) else $error("fuses changed while locked");

  a_serial_gate: assert property (
    cmd_fire && ser && nv[`LFP_NV_SERIAL_EN] |=> res_ref_q && !res_ok_q
  ) else $error("serial command taken with serial enable unprogrammed");

  a_serial_download_enable_fuse_serial_hold: assert property (
    cmd_fire && (op == LFP_OP_FUSE) && ser |=> nv[2] == $past(nv[2])
  ) else $error("serial enable fuse changed over serial path");

  a_erase_keeps_eeprom: assert property (
    accept && (op == LFP_OP_ERASE) && !nv[5] |=> erase_flash_o && !erase_eeprom_o
  ) else $error("EEPROM erased while preserve fuse programmed");

  a_preserve_guard: assert property (
    cmd_fire && (op == LFP_OP_FUSE) && any_lock && nv[5] |=> nv[5]
  ) else $error("preserve fuse programmed with lock bit set");

  a_erase_fuses_kept: assert property (
    accept && (op == LFP_OP_ERASE) |=> nv[5:2] == $past(nv[5:2]) && nv[1:0] == 2'b11
  ) else $error("chip erase altered fuses or left lock bits");

  a_lock_one_way: assert property (
    cmd_fire && (op == LFP_OP_LOCK) |=> (nv[1:0] & ~$past(nv[1:0])) == 2'b00
  ) else $error("lock bit unprogrammed without chip erase");

  a_startup_delay: assert property (
    $rose(startup_done_o) |-> $past(cnt_q) >= $past(cnt_end) - CNT_W'(1)
  ) else $error("start-up ended before its delay");

  c_lock_applied: cover property (cmd_fire && (op == LFP_OP_LOCK) && !ser ##1 locked);
  c_erase_preserve: cover property (cmd_fire && (op == LFP_OP_ERASE) && !nv[5]);
  c_serial_refused: cover property (cmd_fire && ser && !ser_ok);
  c_startup_done: cover property ($rose(startup_done_o));

endmodule : lfp_top

// *** bench/lfp_prog_model.sv ***
`timescale 1ns/10ps
`include "lfp_defines.svh"
// ==================================================
// programmer side, axi4-lite master
module lfp_prog_model (
  // clock
  input wire logic mclk_i,
  // write channels
  output logic [`LFP_ADDR_W-1:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // read channels
  output logic [`LFP_ADDR_W-1:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // cycles of delay before taking an answer, the slow programmer
  int lag = 0;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // handshakes judged at the rising edge, on values from before the slave's update
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ka;
    logic kw;
    ka = 1'b0;
    kw = 1'b0;
    @(posedge mclk_i);
    awaddr_o <= a;
    wdata_o <= v;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    while (!(ka && kw)) begin
      @(posedge mclk_i);
      ka = ka | (awvalid_o & awready_i);
      kw = kw | (wvalid_o & wready_i);
      // released lines do not keep the last value
      if (ka) awvalid_o <= 1'b0;
      if (ka) awaddr_o <= ~a;
      if (kw) wvalid_o <= 1'b0;
      if (kw) wdata_o <= ~v;
    end
    repeat (lag) @(posedge mclk_i);
    bready_o <= 1'b1;
    do @(posedge mclk_i); while (bvalid_i !== 1'b1);
    rs = bresp_i;
    bready_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    do @(posedge mclk_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    araddr_o <= ~a;
    repeat (lag) @(posedge mclk_i);
    rready_o <= 1'b1;
    do @(posedge mclk_i); while (rvalid_i !== 1'b1);
    v = rdata_i;
    rs = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : lfp_prog_model

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`include "lfp_defines.svh"
// ==================================================
// bench top
module tb_top
  import lfp_pkg::*;
;
  logic mclk_i, rst_i, ce_i, nv_blank_i;
  logic [`LFP_ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic fwa, fp, ep, ef, ee, sde, sdone;
  int n_fail = 0;
  int n_compared = 0;
  int n_fp = 0, n_ep = 0, n_ef = 0, n_ee = 0;

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // short start-up count keeps the run brief
  lfp_top #(.STARTUP_CYC_11(20)) u_lfp_top (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .nv_blank_i(nv_blank_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .flash_write_allow_o(fwa),
    .flash_prog_o(fp), .eeprom_prog_o(ep), .erase_flash_o(ef), .erase_eeprom_o(ee),
    .serial_download_en_o(sde), .startup_done_o(sdone));

  lfp_prog_model u_lfp_prog_model (
    .mclk_i(mclk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready));

  // pulse counters, each pulse stands one cycle
  always @(posedge mclk_i) begin
    if (fp === 1'b1) n_fp++;
    if (ep === 1'b1) n_ep++;
    if (ef === 1'b1) n_ef++;
    if (ee === 1'b1) n_ee++;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chk_rs(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_rs
  task automatic cmd(input logic [31:0] c, input logic [31:0] e);
    u_lfp_prog_model.wr(`LFP_REG_CMD, c, r);
    chk_rs(r, `LFP_RESP_OKAY);
    u_lfp_prog_model.rd(`LFP_REG_RESULT, d, r);
    chk(d, e);
  endtask : cmd
  task automatic stat(input logic [31:0] e);
    u_lfp_prog_model.rd(`LFP_REG_STATUS, d, r);
    chk_rs(r, `LFP_RESP_OKAY);
    chk(d, e);
  endtask : stat
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // ==================================================
  // watchdog
  initial begin
    repeat (6000) @(posedge mclk_i);
    n_fail++;
    final_report();
  end

  // ==================================================
  // tests
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    nv_blank_i = 1'b0;
    @(posedge mclk_i);
    nv_blank_i <= 1'b1;
    @(posedge mclk_i);
    nv_blank_i <= 1'b0;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    // release is seen at the fourth edge, done is due nineteen edges on
    repeat (19) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({31'h0, sdone}, 32'h0);
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk({31'h0, sdone}, 32'h1);
    stat(32'h23F);
    chk({31'h0, sde}, 32'h0);
    // refused accesses leave the store alone
    u_lfp_prog_model.wr(`LFP_REG_STATUS, 32'h0, r);
    chk_rs(r, `LFP_RESP_SLVERR);
    u_lfp_prog_model.rd(`LFP_REG_CMD, d, r);
    chk_rs(r, `LFP_RESP_SLVERR);
    chk(d, 32'h0);
    u_lfp_prog_model.rd(4'hC, d, r);
    chk_rs(r, `LFP_RESP_SLVERR);
    chk(d, 32'h0);
    stat(32'h23F);
    cmd(32'h000, 32'h02);
    cmd(32'h006, 32'h62);
    cmd(32'h007, 32'h72);
    cmd(32'h00C, 32'h42);
    // fuses go in before any lock bit
    cmd(32'h602, 32'h21);
    chk({31'h0, sde}, 32'h1);
    stat(32'h21B);
    cmd(32'hF0A, 32'h22);
    cmd(32'h019, 32'h12);
    u_lfp_prog_model.lag = 3;
    cmd(32'h00C, 32'h41);
    cmd(32'h005, 32'h51);
    cmd(32'h021, 32'h11);
    chk({31'h0, fwa}, 32'h0);
    stat(32'h31A);
    cmd(32'h004, 32'h42);
    cmd(32'h005, 32'h52);
    cmd(32'h602, 32'h22);
    chk(32'(n_fp), 32'h1);
    chk(32'(n_ep), 32'h1);
    cmd(32'h003, 32'h31);
    stat(32'h21B);
    chk({31'h0, fwa}, 32'h1);
    chk(32'(n_ee), 32'h0);
    u_lfp_prog_model.lag = 0;
    cmd(32'hE02, 32'h21);
    cmd(32'h011, 32'h11);
    cmd(32'h031, 32'h11);
    stat(32'h239);
    cmd(32'h602, 32'h22);
    cmd(32'h003, 32'h31);
    stat(32'h23B);
    chk(32'(n_ef), 32'h2);
    chk(32'(n_ee), 32'h1);
    final_report();
  end
endmodule : tb_top
